//--- pkg/supervisor_pkg.sv
// Constants shared by the supply supervisor and watchdog block
package supervisor_pkg;

    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned DELAY_LONG_MS  = 200;
    localparam int unsigned DELAY_SHORT_MS = 25;
    localparam int unsigned TOUT_LONG_MS   = 1600;
    localparam int unsigned TOUT_SHORT_MS  = 200;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned DELAY_LONG_CYC  = DELAY_LONG_MS * CYC_PER_MS;
    localparam int unsigned DELAY_SHORT_CYC = DELAY_SHORT_MS * CYC_PER_MS;
    localparam int unsigned TOUT_LONG_CYC   = TOUT_LONG_MS * CYC_PER_MS;
    localparam int unsigned TOUT_SHORT_CYC  = TOUT_SHORT_MS * CYC_PER_MS;

    // ------------------------------------------------------------------
    // Counter width and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W   = 32;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Output phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_HOLD,
        PH_DELAY,
        PH_RUN
    } phase_t;

endpackage

//--- rtl/kick_detect.sv
// Watchdog kick edge detector with undriven-input substitute kicks
`timescale 1ns/1ps

module kick_detect (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic kick_in,
    input  wire logic kick_hiz,
    input  wire logic both_edges,
    output logic      kick_pulse
);

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic prev_r;
    logic fall_w;
    logic rise_w;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= kick_in;
        end
    end

    assign fall_w = prev_r & ~kick_in;
    assign rise_w = ~prev_r & kick_in;

    // Undriven pin counts as a kick every cycle, so no timeout fires
    assign kick_pulse = kick_hiz | fall_w | (both_edges & rise_w);

endmodule

//--- rtl/supply_supervisor_watchdog.sv
// Supply supervisor with release delay, manual reset and watchdog
//
// Functional notes
// [RULE1] Reset output low once powered while supply is under the threshold
// [RULE2] Complementary active-high output high while supply is low
// [RULE3] After supply recovery hold reset for the release delay
// [RULE4] Supply dropping low reasserts reset at once, no delay
// [RULE5] Manual reset low forces outputs active regardless of all else
// [RULE6] Each falling kick edge restarts the watchdog interval
// [RULE7] Missed kick asserts reset for exactly the release delay
// [RULE8] Timeout also restarts the watchdog from its initial state
// [RULE9] Undriven kick input makes internal kicks; watchdog never fires
// [RULE10] Non-A: kick during reset latches reset low permanently
// [RULE11] A variant: kicks during reset do not latch, release proceeds
// [RULE12] A variant: rising or falling kick edge both retrigger
// [RULE13] Watchdog held cleared during any reset, counts after release
// [RULE14] Delay and timeout are counters with per-variant terminal counts
`timescale 1ns/1ps

module supply_supervisor_watchdog #(
    parameter logic [31:0] DELAY_CYC = 32'(supervisor_pkg::DELAY_LONG_CYC),
    parameter logic [31:0] TOUT_CYC  = 32'(supervisor_pkg::TOUT_LONG_CYC),
    parameter bit          A_VARIANT = 1'b0,
    parameter bit          HAS_WDOG  = 1'b1
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic SUPPLY_ABOVE_FALL,
    input  wire logic SUPPLY_ABOVE_RISE,
    input  wire logic MANUAL_RESET_N,
    input  wire logic WATCHDOG_KICK_INPUT,
    input  wire logic KICK_UNDRIVEN,
    output logic      RESET_N,
    output logic      RESET_HI,
    output logic      RESET_LATCHED,
    output logic      WDOG_FIRED
);

    // ------------------------------------------------------------------
    // Kick detection
    // ------------------------------------------------------------------
    logic kick_w;

    kick_detect u_kick (
        .clk        (CLK),
        .rst        (RST),
        .kick_in    (WATCHDOG_KICK_INPUT),
        .kick_hiz   (KICK_UNDRIVEN),        // [RULE9]
        .both_edges (A_VARIANT),            // [RULE12]
        .kick_pulse (kick_w)                // [RULE6]
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    supervisor_pkg::phase_t phase_r;
    supervisor_pkg::phase_t phase_nxt;
    logic [31:0]            dly_r;
    logic [31:0]            dly_nxt;
    logic [31:0]            wd_r;
    logic [31:0]            wd_nxt;
    logic                   latch_r;
    logic                   latch_nxt;
    logic                   fired_r;
    logic                   fired_nxt;
    logic                   rst_out_r;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic force_w;
    logic in_reset_w;
    logic dly_done_w;
    logic tout_w;

    // Manual reset and supply drop bypass the delay entirely
    assign force_w    = ~MANUAL_RESET_N | ~SUPPLY_ABOVE_FALL; // [RULE4] [RULE5]
    assign in_reset_w = (phase_r != supervisor_pkg::PH_RUN);
    assign dly_done_w = (dly_r >= DELAY_CYC - 32'h1);        // [RULE14]
    assign tout_w     = HAS_WDOG && !kick_w
                        && (wd_r >= TOUT_CYC - 32'h1);       // [RULE14]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        phase_nxt = phase_r;
        dly_nxt   = dly_r;
        wd_nxt    = supervisor_pkg::CNT_RST;
        latch_nxt = latch_r;
        fired_nxt = 1'b0;
        // Sticky lock-up, mirrors the part's known trap with active kicks
        if (!A_VARIANT && HAS_WDOG && in_reset_w && kick_w
            && !KICK_UNDRIVEN) begin
            latch_nxt = 1'b1;                                 // [RULE10]
        end
        case (phase_r)
            supervisor_pkg::PH_HOLD: begin
                dly_nxt = supervisor_pkg::CNT_RST;
                if (!force_w && SUPPLY_ABOVE_RISE) begin
                    phase_nxt = supervisor_pkg::PH_DELAY;     // [RULE3]
                end
            end
            supervisor_pkg::PH_DELAY: begin
                if (force_w) begin
                    phase_nxt = supervisor_pkg::PH_HOLD;      // [RULE4]
                    dly_nxt   = supervisor_pkg::CNT_RST;
                // A kick on the release edge itself must still lock reset low
                end else if (dly_done_w && !latch_nxt) begin
                    phase_nxt = supervisor_pkg::PH_RUN;       // [RULE3] [RULE11]
                    dly_nxt   = supervisor_pkg::CNT_RST;
                end else if (!dly_done_w) begin
                    dly_nxt = dly_r + 32'h1;                  // [RULE7]
                end
            end
            supervisor_pkg::PH_RUN: begin
                if (force_w) begin
                    phase_nxt = supervisor_pkg::PH_HOLD;      // [RULE4] [RULE5]
                end else if (tout_w) begin
                    phase_nxt = supervisor_pkg::PH_DELAY;     // [RULE7] [RULE8]
                    fired_nxt = 1'b1;
                end else if (!kick_w && HAS_WDOG) begin
                    wd_nxt = wd_r + 32'h1;                    // [RULE6] [RULE13]
                end
            end
            default: begin
                phase_nxt = supervisor_pkg::PH_HOLD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            phase_r <= supervisor_pkg::PH_HOLD;               // [RULE1]
            dly_r   <= supervisor_pkg::CNT_RST;
            wd_r    <= supervisor_pkg::CNT_RST;
            latch_r <= 1'b0;
            fired_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            dly_r   <= dly_nxt;
            wd_r    <= wd_nxt;                                // [RULE13]
            latch_r <= latch_nxt;
            fired_r <= fired_nxt;
        end
    end

    // Output flop reflects force immediately on the next edge
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rst_out_r <= 1'b1;
        end else begin
            rst_out_r <= (phase_nxt != supervisor_pkg::PH_RUN); // [RULE1]
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign RESET_N       = ~rst_out_r;                        // [RULE1]
    assign RESET_HI      = rst_out_r;                         // [RULE2]
    assign RESET_LATCHED = latch_r;
    assign WDOG_FIRED    = fired_r;

endmodule

//--- verification/supervisor_monitor.sv
// Checker for the supervisor output timing
`timescale 1ns/1ps
module supervisor_monitor #(
    parameter logic [31:0] DELAY_CYC = 32'd20, TOUT_CYC = 32'd50
) (
    input wire logic CLK, RST, SUPPLY_ABOVE_FALL, SUPPLY_ABOVE_RISE,
    input wire logic MANUAL_RESET_N, WATCHDOG_KICK_INPUT, KICK_UNDRIVEN,
    input wire logic RESET_N, RESET_HI, RESET_LATCHED, WDOG_FIRED
);
    // Cycles since the last falling kick; reset time never counts
    logic [31:0] idle_r;
    always_ff @(posedge CLK)
        idle_r <= (!RESET_N || $fell(WATCHDOG_KICK_INPUT)) ? 32'h0
                : idle_r + 32'h1;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_held_low; (!RESET_N)[*8]; endsequence
    AST_MR_FORCE: assert property (
        !MANUAL_RESET_N |=> !RESET_N) else $error("manual reset ignored");
    AST_SUPPLY_LOW: assert property (
        !SUPPLY_ABOVE_FALL |=> !RESET_N) else $error("low supply ignored");
    AST_COMPLEMENT: assert property (
        RESET_HI == !RESET_N) else $error("outputs not complementary");
    AST_RELEASE: assert property (
        $rose(RESET_N) |-> !$past(RESET_N, 8) && $past(SUPPLY_ABOVE_RISE)
        && $past(MANUAL_RESET_N)) else $error("early release");
    AST_WDOG_PULSE: assert property (
        WDOG_FIRED |-> ##[0:1] s_held_low) else $error("short timeout reset");
    AST_WDOG_WAIT: assert property (
        WDOG_FIRED |-> $past(idle_r) >= TOUT_CYC - 3) else $error("early fire");
    AST_UNDRIVEN: assert property (
        KICK_UNDRIVEN [*3] |-> !WDOG_FIRED) else $error("fired undriven");
    AST_LATCH: assert property (
        RESET_LATCHED |-> !RESET_N ##1 RESET_LATCHED) else $error("latch lost");
endmodule
bind supply_supervisor_watchdog supervisor_monitor #(.DELAY_CYC(DELAY_CYC),
    .TOUT_CYC(TOUT_CYC)) supervisor_monitor_inst (.CLK(CLK), .RST(RST),
    .SUPPLY_ABOVE_FALL(SUPPLY_ABOVE_FALL), .RESET_N(RESET_N),
    .SUPPLY_ABOVE_RISE(SUPPLY_ABOVE_RISE), .MANUAL_RESET_N(MANUAL_RESET_N),
    .WATCHDOG_KICK_INPUT(WATCHDOG_KICK_INPUT), .KICK_UNDRIVEN(KICK_UNDRIVEN),
    .RESET_HI(RESET_HI), .RESET_LATCHED(RESET_LATCHED), .WDOG_FIRED(WDOG_FIRED));

//--- verification/kick_partner.sv
// Processor model toggling the watchdog kick pin
`timescale 1ns/1ps
module kick_partner (
    input  wire logic       clk, en, wild, ok,
    input  wire logic [7:0] period,
    output logic            kick
);
    logic [7:0] cnt_r = 8'h00;
    initial kick = 1'b1;
    // Silent while reset is low, as a decoupled pin would be, unless wild
    always @(negedge clk)
        if (en && (ok || wild)) begin
            cnt_r <= (cnt_r >= period) ? 8'h00 : cnt_r + 8'h01;
            kick <= kick ^ (cnt_r >= period);
        end
endmodule

//--- verification/test_supply_supervisor_watchdog.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
module test_supply_supervisor_watchdog;
    localparam int DLY = 20, TOUT = 50;
    logic       clk = 1'b0, rst = 1'b1, fall_ok = 1'b0, rise_ok = 1'b0;
    logic       mr_n = 1'b1, undrv = 1'b0, en = 1'b0, wild = 1'b0;
    logic [7:0] period = 8'd4;
    wire logic  kick, rst_n, rst_hi, latched, fired;
    int         fails, checks_done, fires, exp_fires, seed = 23454;
    supply_supervisor_watchdog #(.DELAY_CYC(32'(DLY)), .TOUT_CYC(32'(TOUT)))
        supply_supervisor_watchdog_inst (.CLK(clk), .RST(rst),
        .SUPPLY_ABOVE_FALL(fall_ok), .SUPPLY_ABOVE_RISE(rise_ok),
        .MANUAL_RESET_N(mr_n), .WATCHDOG_KICK_INPUT(kick),
        .KICK_UNDRIVEN(undrv), .RESET_N(rst_n), .RESET_HI(rst_hi),
        .RESET_LATCHED(latched), .WDOG_FIRED(fired));
    kick_partner kick_partner_inst (.clk(clk), .en(en), .wild(wild),
        .ok(rst_n), .period(period), .kick(kick));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) fires += (fired === 1'b1);
    task automatic chk(input logic got, input logic exp);
        checks_done++;
        fails += (got !== exp);
        if (got !== exp)
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic summarize;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000 fails++;
        summarize();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        // Pass 3 stops kicking, so two timeouts land inside the wait
        for (int m = 0; m < 5; m++) begin
            {en, undrv} = {1'b0, m == 4};
            @(negedge clk);
            mr_n = (m % 2 == 0);
            {fall_ok, rise_ok} = {2{m % 2 == 1}};
            repeat (2) @(negedge clk);
            chk(rst_n, 1'b0);
            chk(rst_hi, 1'b1);
            repeat ($unsigned($random(seed)) % 8 + 1) @(negedge clk);
            {mr_n, fall_ok, rise_ok} = 3'b111;
            repeat (DLY - 2) @(negedge clk);
            chk(rst_n, 1'b0);
            repeat (5) @(negedge clk);
            chk(rst_n, 1'b1);
            chk(rst_hi, 1'b0);
            {en, period} = {m < 3, 8'($unsigned($random(seed)) % 19 + 2)};
            exp_fires += 2 * (m == 3);
            repeat (150) @(negedge clk);
            chk(fires == exp_fires, 1'b1);
        end
        {undrv, en, wild, period} = {1'b0, 1'b1, 1'b1, 8'd4};
        {fall_ok, rise_ok} = 2'b00;
        repeat (DLY) @(negedge clk);
        {fall_ok, rise_ok} = 2'b11;
        repeat (DLY + 5) @(negedge clk);
        chk(latched, 1'b1);
        chk(rst_n, 1'b0);
        // Only a fresh reset clears the lock-up; kicks stopped so it stays clear
        {en, wild} = 2'b00;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (DLY + 5) @(negedge clk);
        chk(latched, 1'b0);
        chk(rst_n, 1'b1);
        summarize();
    end
endmodule
